// ==== pcfg_pkg.sv ====
// constants for the port 2 / port 3 configuration block
package pcfg_pkg;
	localparam int PCFG_W = 8;
	localparam logic [7:0] PCFG_ADDR_P3_MODE = 8'hA7;
	localparam logic [7:0] PCFG_ADDR_P3_DATA = 8'hB0;
	localparam logic [7:0] PCFG_ADDR_P2_SKIP = 8'hD6;
	localparam logic [7:0] PCFG_ADDR_P3_ANA = 8'hF4;
	localparam logic [7:0] PCFG_ADDR_P2_MODE = 8'hA6;
	localparam logic [7:0] PCFG_ADDR_P2_ANA = 8'hF3;
	localparam logic [7:0] PCFG_RST_P3_MODE = 8'h00;
	localparam logic [7:0] PCFG_RST_P3_DATA = 8'hFF;
	localparam logic [7:0] PCFG_RST_P2_SKIP = 8'h00;
	localparam logic [7:0] PCFG_RST_P3_ANA = 8'h1F;
	localparam logic [7:0] PCFG_RST_P2_MODE = 8'h00;
	localparam logic [7:0] PCFG_RST_P2_ANA = 8'hFF;
	localparam logic [7:0] PCFG_P3_IMPL = 8'h1F;
	localparam logic [7:0] PCFG_P2_XBAR = 8'h0F;
	localparam logic [7:0] PCFG_BONDED_P2 = 8'hFF;
	localparam logic [7:0] PCFG_BONDED_P3 = 8'h1F;
endpackage

// ==== pcfg_port23.sv ====
// configuration and data logic for ports 2 and 3
`timescale 1ns/1ps
module pcfg_port23
	import pcfg_pkg::*;
(
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	output logic [7:0] sfr_rdata_o,
	input wire logic [pcfg_pkg::PCFG_W-1:0] p2_out_i,
	input wire logic [pcfg_pkg::PCFG_W-1:0] p2_pin_i,
	output logic [pcfg_pkg::PCFG_W-1:0] p2_pin_o,
	output logic [pcfg_pkg::PCFG_W-1:0] p2_pin_oe_o,
	output logic [pcfg_pkg::PCFG_W-1:0] p2_pullup_en_o,
	output logic [pcfg_pkg::PCFG_W-1:0] p2_in_o,
	output logic [pcfg_pkg::PCFG_W-1:0] p2_xbar_avail_o,
	input wire logic [pcfg_pkg::PCFG_W-1:0] p3_pin_i,
	output logic [pcfg_pkg::PCFG_W-1:0] p3_pin_o,
	output logic [pcfg_pkg::PCFG_W-1:0] p3_pin_oe_o,
	output logic [pcfg_pkg::PCFG_W-1:0] p3_pullup_en_o
);
	import pcfg_pkg::*;

	logic [7:0] port2_output_drive_mode_reg;
	logic [7:0] port2_crossbar_exclude_reg;
	logic [7:0] port2_analog_select_reg;
	logic [7:0] port3_data_latch_reg;
	logic [7:0] port3_analog_select_reg;
	logic [7:0] port3_output_drive_mode_reg;
	logic [7:0] rdata_next;
	logic [7:0] p3_read_value;
	logic [7:0] p2_live;
	logic [7:0] p3_live;
	logic wr_p2_mode;
	logic wr_p2_skip;
	logic wr_p2_ana;
	logic wr_p3_data;
	logic wr_p3_ana;
	logic wr_p3_mode;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	// one pin's drive enable: a zero always sinks, a one drives only in push-pull;
	// analog and unbonded pins never drive
	function automatic logic pin_drives(
		input logic digital,
		input logic bonded,
		input logic value,
		input logic push_pull
	);
		return digital & bonded & (~value | push_pull);
	endfunction

	// one pin's read value: analog and absent pins read one, digital pins the pad
	function automatic logic pin_reads(
		input logic digital,
		input logic present,
		input logic pad
	);
		return ~(digital & present) | (pad & digital & present);
	endfunction

	// a write strobe lands only on the register whose address matches
	assign wr_p2_mode = sfr_wr_i & hit(sfr_addr_i, PCFG_ADDR_P2_MODE);
	assign wr_p2_skip = sfr_wr_i & hit(sfr_addr_i, PCFG_ADDR_P2_SKIP);
	assign wr_p2_ana = sfr_wr_i & hit(sfr_addr_i, PCFG_ADDR_P2_ANA);
	assign wr_p3_data = sfr_wr_i & hit(sfr_addr_i, PCFG_ADDR_P3_DATA);
	assign wr_p3_ana = sfr_wr_i & hit(sfr_addr_i, PCFG_ADDR_P3_ANA);
	assign wr_p3_mode = sfr_wr_i & hit(sfr_addr_i, PCFG_ADDR_P3_MODE);

	// a pin is live only when it is bonded out and set digital
	assign p2_live = port2_analog_select_reg & PCFG_BONDED_P2;
	assign p3_live = port3_analog_select_reg & PCFG_BONDED_P3;

	// unbonded pin bits store only in the port 3 data latch; they simply reach no pad
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			port2_output_drive_mode_reg <= PCFG_RST_P2_MODE;
		end else if (wr_p2_mode) begin
			port2_output_drive_mode_reg <= sfr_wdata_i;
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			port2_crossbar_exclude_reg <= PCFG_RST_P2_SKIP;
		end else if (wr_p2_skip) begin
			port2_crossbar_exclude_reg <= sfr_wdata_i;
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			port2_analog_select_reg <= PCFG_RST_P2_ANA;
		end else if (wr_p2_ana) begin
			port2_analog_select_reg <= sfr_wdata_i;
		end
	end

	// data goes straight to the pad logic, the crossbar has no say on this port
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			port3_data_latch_reg <= PCFG_RST_P3_DATA;
		end else if (wr_p3_data) begin
			port3_data_latch_reg <= sfr_wdata_i;
		end
	end

	// bits 7 to 5 are not kept, so they read back zero whatever was written
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			port3_analog_select_reg <= PCFG_RST_P3_ANA;
		end else if (wr_p3_ana) begin
			port3_analog_select_reg <= sfr_wdata_i & PCFG_P3_IMPL;
		end
	end

	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			port3_output_drive_mode_reg <= PCFG_RST_P3_MODE;
		end else if (wr_p3_mode) begin
			port3_output_drive_mode_reg <= sfr_wdata_i & PCFG_P3_IMPL;
		end
	end

	// bits 7 to 5 of the data read come back as one, like an absent pin;
	// the pad is read with no synchroniser since pins are taken as synchronous
	for (genvar gr = 0; gr < PCFG_W; gr++) begin : g_p3_read
		assign p3_read_value[gr] = pin_reads(port3_analog_select_reg[gr], PCFG_P3_IMPL[gr],
			p3_pin_i[gr]);
	end

	always_comb begin
		rdata_next = 8'h00;
		case (sfr_addr_i)
			PCFG_ADDR_P2_MODE: begin
				rdata_next = port2_output_drive_mode_reg;
			end
			PCFG_ADDR_P2_SKIP: begin
				rdata_next = port2_crossbar_exclude_reg;
			end
			PCFG_ADDR_P2_ANA: begin
				rdata_next = port2_analog_select_reg;
			end
			PCFG_ADDR_P3_ANA: begin
				rdata_next = port3_analog_select_reg;
			end
			PCFG_ADDR_P3_MODE: begin
				rdata_next = port3_output_drive_mode_reg;
			end
			PCFG_ADDR_P3_DATA: begin
				rdata_next = p3_read_value;
			end
			default: begin
				rdata_next = 8'h00;
			end
		endcase
	end

	// read data is held between reads, so a slow reader may sample it late
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sfr_rdata_o <= 8'h00;
		end else if (sfr_rd_i) begin
			sfr_rdata_o <= rdata_next;
		end
	end

	// per-pin pad logic, registered so every output leaves a flip-flop
	for (genvar g2 = 0; g2 < PCFG_W; g2++) begin : g_p2_pin
		always_ff @(posedge mclk_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				p2_pin_o[g2] <= 1'h0;
				p2_pin_oe_o[g2] <= 1'h0;
				p2_pullup_en_o[g2] <= 1'h0;
				p2_in_o[g2] <= 1'h0;
			end else begin
				p2_pin_o[g2] <= p2_out_i[g2] & p2_live[g2];
				p2_pin_oe_o[g2] <= pin_drives(port2_analog_select_reg[g2], PCFG_BONDED_P2[g2],
					p2_out_i[g2], port2_output_drive_mode_reg[g2]);
				p2_pullup_en_o[g2] <= p2_live[g2];
				p2_in_o[g2] <= p2_pin_i[g2] & port2_analog_select_reg[g2];
			end
		end
	end

	// skip bits above pin 3 are kept but never route anything
	for (genvar gx = 0; gx < PCFG_W; gx++) begin : g_xbar
		always_ff @(posedge mclk_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				p2_xbar_avail_o[gx] <= 1'h0;
			end else begin
				p2_xbar_avail_o[gx] <= ~port2_crossbar_exclude_reg[gx] & PCFG_P2_XBAR[gx];
			end
		end
	end

	// unbonded pins are masked here too, so nothing reaches an absent pad
	for (genvar g3 = 0; g3 < PCFG_W; g3++) begin : g_p3_pin
		always_ff @(posedge mclk_i or negedge reset_n_i) begin
			if (!reset_n_i) begin
				p3_pin_o[g3] <= 1'h0;
				p3_pin_oe_o[g3] <= 1'h0;
				p3_pullup_en_o[g3] <= 1'h0;
			end else begin
				p3_pin_o[g3] <= port3_data_latch_reg[g3] & p3_live[g3];
				p3_pin_oe_o[g3] <= pin_drives(port3_analog_select_reg[g3], PCFG_BONDED_P3[g3],
					port3_data_latch_reg[g3], port3_output_drive_mode_reg[g3]);
				p3_pullup_en_o[g3] <= p3_live[g3];
			end
		end
	end
endmodule

// ==== pcfg_sva.sv ====
// pin and read checks for the port 2 / port 3 block
`timescale 1ns/1ps
module pcfg_sva import pcfg_pkg::*; (
	input wire logic mclk_i, reset_n_i, sfr_rd_i,
	input wire logic [7:0] sfr_addr_i, sfr_rdata_o, p2_out_i, p2_pin_i, p2_pin_o,
	input wire logic [7:0] p2_pin_oe_o, p2_pullup_en_o, p2_in_o, p2_xbar_avail_o,
	input wire logic [7:0] p3_pin_oe_o, p3_pullup_en_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	AST_XBAR_HI: assert property (p2_xbar_avail_o[7:4] == 4'h0) else $error("xbar hi");
	AST_P3_UNB: assert property (((p3_pin_oe_o | p3_pullup_en_o) & ~PCFG_BONDED_P3) == 8'h00)
		else $error("unbonded pin active");
	AST_ANA_OE: assert property (((p2_pin_oe_o & ~p2_pullup_en_o)
		| (p3_pin_oe_o & ~p3_pullup_en_o)) == 8'h00) else $error("analog pin driven");
	AST_ANA_RX: assert property ((p2_in_o & ~p2_pullup_en_o) == 8'h00) else $error("rx on");
	AST_P2_RX: assert property (((p2_in_o ^ $past(p2_pin_i)) & p2_pullup_en_o) == 8'h00)
		else $error("p2 rx level");
	AST_P2_VAL: assert property (((p2_pin_o ^ $past(p2_out_i)) & p2_pin_oe_o) == 8'h00)
		else $error("p2 value");
	AST_P2_LOW: assert property ((~$past(p2_out_i) & p2_pullup_en_o & ~p2_pin_oe_o) == 8'h00)
		else $error("p2 low not driven");
	AST_ANA_RD: assert property ($past(sfr_rd_i) && $past(sfr_addr_i) == PCFG_ADDR_P3_ANA
		|-> sfr_rdata_o[7:5] == 3'h0) else $error("p3 analog top bits");
	AST_MODE_RD: assert property ($past(sfr_rd_i) && $past(sfr_addr_i) == PCFG_ADDR_P3_MODE
		|-> sfr_rdata_o[7:5] == 3'h0) else $error("p3 mode top bits");
endmodule
bind pcfg_port23 pcfg_sva i_sva (.*);

// ==== pcfg_pads.sv ====
// pad model: resolves each pin from block drive, pull-ups and outside load
`timescale 1ns/1ps
module pcfg_pads (
	input wire logic mclk_i,
	input wire logic [7:0] oe_i, val_i, pu_i, low_i,
	output logic [7:0] pad_o
);
	logic [7:0] junk_reg = 8'h5A;
	// a floating pin wanders, so nothing may lean on its last level
	always @(posedge mclk_i) junk_reg <= ~junk_reg;
	assign pad_o = (oe_i & val_i) | (~oe_i & ~low_i & (pu_i | junk_reg));
endmodule

// ==== testbench.sv ====
// self-checking bench for the port 2 / port 3 block
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
	$display("CHECK FAILED %0t got %h", $time, g); end end
module testbench;
	import pcfg_pkg::*;
	logic mclk_i = 1'h0, reset_n_i = 1'h0, wr = 1'h0, rd = 1'h0;
	logic [7:0] addr = 8'h00, wd = 8'h00, p2o = 8'h3C, p3e = 8'h00, rdat, p2i, p3i;
	logic [7:0] p2po, p2oe, p2pu, p2in, p2xb, p3po, p3oe, p3pu;
	logic [7:0] ad[6] = '{8'hA7, 8'hB0, 8'hD6, 8'hF4, 8'hA6, 8'hF3};
	logic [7:0] rv[6] = '{8'h00, 8'hFF, 8'h00, 8'h1F, 8'h00, 8'hFF};
	logic [7:0] wa[6] = '{8'hA7, 8'hF4, 8'hD6, 8'hA6, 8'hF3, 8'h00};
	logic [7:0] wv[6] = '{8'hFF, 8'hFF, 8'hA3, 8'h0F, 8'hFC, 8'hFF};
	logic [7:0] wr_exp[6] = '{8'h1F, 8'h1F, 8'hA3, 8'h0F, 8'hFC, 8'h00};
	int err_total = 0, checks_done = 0, cyc = 0;
	initial forever #20 mclk_i = ~mclk_i;
	pcfg_port23 i_dut (.mclk_i, .reset_n_i, .sfr_addr_i(addr), .sfr_wdata_i(wd), .sfr_wr_i(wr),
		.sfr_rd_i(rd), .sfr_rdata_o(rdat), .p2_out_i(p2o), .p2_pin_i(p2i), .p2_pin_o(p2po),
		.p2_pin_oe_o(p2oe), .p2_pullup_en_o(p2pu), .p2_in_o(p2in), .p2_xbar_avail_o(p2xb),
		.p3_pin_i(p3i), .p3_pin_o(p3po), .p3_pin_oe_o(p3oe), .p3_pullup_en_o(p3pu));
	pcfg_pads i_p2 (.mclk_i, .oe_i(p2oe), .val_i(p2po), .pu_i(p2pu), .low_i(8'h00), .pad_o(p2i));
	pcfg_pads i_p3 (.mclk_i, .oe_i(p3oe), .val_i(p3po), .pu_i(p3pu), .low_i(p3e), .pad_o(p3i));
	task automatic complete_run();
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// one access, then a spare cycle so pad outputs have settled on return
	task automatic acc(input logic w, input logic [7:0] a, d);
		@(negedge mclk_i);
		{wr, rd, addr, wd} = {w, !w, a, d};
		@(negedge mclk_i);
		{wr, rd} = 2'h0;
		@(negedge mclk_i);
	endtask
	always @(posedge mclk_i) if (++cyc > 500) begin err_total++; complete_run(); end
	initial begin
		repeat (3) @(negedge mclk_i);
		reset_n_i = 1'h1;
		for (int i = 0; i < 6; i++) begin acc(0, ad[i], 8'h00); `CHK(rdat, rv[i]) end
		`CHK({p2xb, p3oe}, 16'h0F00)
		for (int i = 0; i < 6; i++) begin
			acc(1, wa[i], wv[i]);
			acc(0, wa[i], 8'h00);
			`CHK(rdat, wr_exp[i])
		end
		`CHK({p2oe, p2po & p2oe, p2in, p2xb}, 32'hCC0C3C0C)
		`CHK({p3oe, p3po}, 16'h1F1F)
		acc(1, 8'hB0, 8'h0A);
		`CHK({p3oe, p3po}, 16'h1F0A)
		acc(1, 8'hA7, 8'h00);
		`CHK(p3oe, 8'h15)
		acc(1, 8'hF4, 8'h1C);
		p3e = 8'h13;
		acc(1, 8'hB0, 8'hFF);
		`CHK({p3pu, p3oe}, 16'h1C00)
		acc(0, 8'hB0, 8'h00);
		`CHK(rdat, 8'hEF)
		complete_run();
	end
endmodule
